/* File: design/spsf_serial_port.sv */
// Functional notes
// - Hardware sets receive overrun; only a software zero clears it.
// - Sync mode shift clock: system/12 when check bit clear, /4 when set.
// - Mode 1, check clear: any stop bit raises receive done.
// - Mode 1, check set: only stop bit of one raises receive done.
// - Nine-bit modes: check set accepts only ninth bit one frames.
// - Transmit done at end of bit 8 sync, at stop start async.
// - Upper control bits: mode/check when view 0, error flags when 1.
// - Address compare uses only bits whose mask bit is one.
`default_nettype none
module spsf_serial_port
  import spsf_pkg::*;
(
  input  wire logic      ref_clk_i,
  input  wire logic      rst_n_i,
  input  wire spsf_req_s req_i,
  output logic [7:0]     rdata_o,
  output logic           irq_o,
  input  wire logic      rxd_i,
  output logic           rxd_o,
  output logic           rxd_oe_o,
  output logic           txd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Register state
  logic [1:0]       mode_q;
  logic             mpc_q, fe_q, ov_q, col_q;
  logic             ren_q, tb8_q, rb8_q, ti_q, ri_q, view_q;
  logic [7:0]       rbuf_q, slave_address_match_q, slave_address_mask_q;
  logic [IRQ_W-1:0] istat_q, imask_q;
  // Link state
  spsf_tx_e         tx_st_q;
  spsf_rx_e         rx_st_q;
  logic [10:0]      tx_sh_q;
  logic [9:0]       rx_sh_q;
  logic [3:0]       tx_cnt_q, rx_cnt_q;
  logic [15:0]      tx_tmr_q, rx_tmr_q;
  logic             rxd_m_q, rxd_s_q, rxd_p_q;

  // Bus decode
  wire wr_ctrl  = req_i.wr && (req_i.addr == ADDR_CTRL);
  wire wr_data  = req_i.wr && (req_i.addr == ADDR_DATA);
  wire rd_istat = req_i.rd && (req_i.addr == ADDR_ISTAT);
  wire [7:0] wd = req_i.wdata;

  wire sync_mode = (mode_q == MODE_SYNC);
  wire a8_mode   = (mode_q == MODE_A8);
  wire [15:0] sync_per = mpc_q ? SYNC_DIV_FAST : SYNC_DIV_SLOW;
  wire [15:0] bit_per  = sync_mode ? sync_per : BIT_CYC;
  wire [15:0] half_per = {1'b0, bit_per[15:1]};

  // Transmit path
  wire tx_busy  = (tx_st_q == SPSF_TX_SHIFT);
  wire tx_start = wr_data && !tx_busy;
  wire tx_tick  = tx_busy && (tx_tmr_q == 16'h0000);
  wire [3:0] tx_cnt_dec = tx_cnt_q - 4'h1;
  // done at bit 8 end or stop start
  wire tx_done_ev = tx_tick &&
                    (sync_mode ? (tx_cnt_dec == 4'h0) : (tx_cnt_dec == 4'h1));
  // A buffer write mid-frame is dropped and never sent, so it is flagged
  wire col_ev     = wr_data && tx_busy;
  wire [10:0] tx_load = sync_mode ? {3'b111, wd} :
                        a8_mode   ? {2'b11, wd, 1'b0} :
                                    {1'b1, tb8_q, wd, 1'b0};
  wire [3:0] tx_bits  = sync_mode ? SYNC_BITS : (a8_mode ? A8_BITS : A9_BITS);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx_st_q  <= SPSF_TX_IDLE;
      tx_sh_q  <= 11'h7FF;
      tx_cnt_q <= 4'h0;
      tx_tmr_q <= 16'h0000;
    end else begin
      case (tx_st_q)
        SPSF_TX_IDLE: begin
          if (tx_start) begin
            tx_st_q  <= SPSF_TX_SHIFT;
            tx_sh_q  <= tx_load;
            tx_cnt_q <= tx_bits;
            tx_tmr_q <= bit_per - 16'h0001;
          end
        end
        SPSF_TX_SHIFT: begin
          if (tx_tick) begin
            tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
            tx_cnt_q <= tx_cnt_dec;
            tx_tmr_q <= bit_per - 16'h0001;
            if (tx_cnt_dec == 4'h0) begin
              tx_st_q <= SPSF_TX_IDLE;
            end
          end else begin
            tx_tmr_q <= tx_tmr_q - 16'h0001;
          end
        end
        default: tx_st_q <= SPSF_TX_IDLE;
      endcase
    end
  end

  // Receive path; the first sync stage feeds only the second
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
      rxd_p_q <= 1'b1;
    end else begin
      rxd_m_q <= rxd_i;
      rxd_s_q <= rxd_m_q;
      rxd_p_q <= rxd_s_q;
    end
  end

  wire rx_tick  = (rx_tmr_q == 16'h0000);
  wire [3:0] rx_cnt_dec = rx_cnt_q - 4'h1;
  wire [9:0] rx_nsh = {rxd_s_q, rx_sh_q[9:1]};
  wire rx_last  = rx_tick && (rx_cnt_dec == 4'h0);
  wire rx_fin   = rx_last &&
                  ((rx_st_q == SPSF_RX_DATA) || (rx_st_q == SPSF_RX_SYNC));
  wire [7:0] rx_byte = (rx_st_q == SPSF_RX_SYNC) ? rx_nsh[9:2] :
                       a8_mode ? rx_nsh[8:1] : rx_nsh[7:0];
  wire rx_ninth = a8_mode ? rx_nsh[9] : rx_nsh[8];
  wire rx_stop  = rx_nsh[9];
  wire addr_hit = (((rx_byte ^ slave_address_match_q) & slave_address_mask_q) == 8'h00);
  // acceptance by mode and check bit
  wire rx_ok    = sync_mode || !mpc_q ||
                  (a8_mode ? rx_stop : (rx_ninth && addr_hit));
  wire rx_acc   = rx_fin && rx_ok;
  wire fe_ev    = rx_fin && !sync_mode && !rx_stop;
  // new frame while the last is unread
  wire ov_ev    = rx_acc && ri_q;
  // done raised on the final sample
  wire ri_ev    = rx_acc && !ri_q;
  wire a_start  = ren_q && !sync_mode && rxd_p_q && !rxd_s_q;
  wire s_start  = ren_q && sync_mode && !ri_q && !tx_busy;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_st_q  <= SPSF_RX_IDLE;
      rx_sh_q  <= 10'h000;
      rx_cnt_q <= 4'h0;
      rx_tmr_q <= 16'h0000;
    end else begin
      rx_tmr_q <= rx_tmr_q - 16'h0001;
      case (rx_st_q)
        SPSF_RX_IDLE: begin
          if (a_start) begin
            rx_st_q  <= SPSF_RX_START;
            rx_tmr_q <= HALF_CYC - 16'h0001;
          end else if (s_start) begin
            rx_st_q  <= SPSF_RX_SYNC;
            rx_cnt_q <= SYNC_BITS;
            rx_tmr_q <= bit_per - 16'h0001;
          end
        end
        SPSF_RX_START: begin
          if (rx_tick) begin
            // A glitch shorter than half a bit is not a start bit
            rx_st_q  <= rxd_s_q ? SPSF_RX_IDLE : SPSF_RX_DATA;
            rx_cnt_q <= a8_mode ? A8_SAMPLES : A9_SAMPLES;
            rx_tmr_q <= bit_per - 16'h0001;
          end
        end
        SPSF_RX_DATA, SPSF_RX_SYNC: begin
          if (rx_tick) begin
            rx_sh_q  <= rx_nsh;
            rx_cnt_q <= rx_cnt_dec;
            rx_tmr_q <= bit_per - 16'h0001;
            if (rx_cnt_dec == 4'h0) begin
              rx_st_q <= SPSF_RX_IDLE;
            end
          end
        end
        default: rx_st_q <= SPSF_RX_IDLE;
      endcase
    end
  end

  // Control/status register; hardware sets win over software clears
  wire view_hi = wr_ctrl && !view_q;
  wire flag_wr = wr_ctrl && view_q;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      {mode_q, mpc_q} <= 3'b000;
      {fe_q, ov_q, col_q} <= 3'b000;
    end else begin
      // upper bits steered by the view
      if (view_hi) begin
        {mode_q, mpc_q} <= wd[BIT_HI:BIT_LO];
      end
      // cleared only by a software zero
      fe_q  <= fe_ev  || (fe_q  && !(flag_wr && !wd[BIT_HI]));
      ov_q  <= ov_ev  || (ov_q  && !(flag_wr && !wd[BIT_MID]));
      col_q <= col_ev || (col_q && !(flag_wr && !wd[BIT_LO]));
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      {ren_q, tb8_q, rb8_q, ti_q, ri_q} <= 5'h00;
    end else begin
      ren_q <= wr_ctrl ? wd[BIT_REN] : ren_q;
      tb8_q <= wr_ctrl ? wd[BIT_TB8] : tb8_q;
      rb8_q <= (ri_ev && !sync_mode) ? rx_ninth :
               (wr_ctrl ? wd[BIT_RB8] : rb8_q);
      ti_q  <= tx_done_ev || (wr_ctrl ? wd[BIT_TI] : ti_q);
      ri_q  <= ri_ev || (wr_ctrl ? wd[BIT_RI] : ri_q);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rbuf_q  <= RST_BYTE;
      slave_address_match_q <= RST_BYTE;
      slave_address_mask_q <= RST_BYTE;
      view_q  <= 1'b0;
      imask_q <= '0;
    end else begin
      if (ri_ev) rbuf_q <= rx_byte;
      if (req_i.wr && req_i.addr == ADDR_SLAVE_ADDRESS_MATCH) slave_address_match_q <= wd;
      if (req_i.wr && req_i.addr == ADDR_SLAVE_ADDRESS_MASK) slave_address_mask_q <= wd;
      if (req_i.wr && req_i.addr == ADDR_VIEW)  view_q  <= wd[BIT_VIEW];
      if (req_i.wr && req_i.addr == ADDR_IMASK) imask_q <= wd[IRQ_W-1:0];
    end
  end

  // Interrupt status, cleared by reading it; an event in that cycle stays
  wire [IRQ_W-1:0] irq_ev = {col_ev, ov_ev, fe_ev, ri_ev, tx_done_ev};
  wire [IRQ_W-1:0] istat_d = (rd_istat ? '0 : istat_q) | irq_ev;

  // read view of the upper bits
  wire [2:0] ctrl_hi = view_q ? {fe_q, ov_q, col_q} : {mode_q, mpc_q};
  wire [7:0] ctrl_rd = {ctrl_hi, ren_q, tb8_q, rb8_q, ti_q, ri_q};
  wire [7:0] rd_mux  =
    (req_i.addr == ADDR_CTRL)  ? ctrl_rd :
    (req_i.addr == ADDR_DATA)  ? rbuf_q :
    (req_i.addr == ADDR_SLAVE_ADDRESS_MATCH) ? slave_address_match_q :
    (req_i.addr == ADDR_SLAVE_ADDRESS_MASK) ? slave_address_mask_q :
    (req_i.addr == ADDR_VIEW)  ? {7'h00, view_q} :
    (req_i.addr == ADDR_ISTAT) ? {3'h0, istat_q} :
    (req_i.addr == ADDR_IMASK) ? {3'h0, imask_q} : 8'h00;

  // Pin drive: in sync mode the transmit pin carries the shift clock
  wire sync_tx  = tx_busy && sync_mode;
  wire sync_rx  = (rx_st_q == SPSF_RX_SYNC);
  wire clk_tx   = (tx_tmr_q < half_per);
  wire clk_rx   = (rx_tmr_q < half_per);
  wire txd_d    = sync_tx ? clk_tx : (sync_rx ? clk_rx :
                  (sync_mode ? 1'b1 : tx_sh_q[0]));

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      istat_q  <= '0;
      rdata_o  <= RST_BYTE;
      irq_o    <= 1'b0;
      txd_o    <= 1'b1;
      rxd_o    <= 1'b1;
      rxd_oe_o <= 1'b0;
    end else begin
      istat_q  <= istat_d;
      rdata_o  <= req_i.rd ? rd_mux : RST_BYTE;
      irq_o    <= |(istat_d & imask_q);
      txd_o    <= txd_d;
      rxd_o    <= sync_tx ? tx_sh_q[0] : 1'b1;
      rxd_oe_o <= sync_tx;
    end
  end
endmodule : spsf_serial_port
`default_nettype wire

/* File: include/spsf_pkg.sv */
`default_nettype none
package spsf_pkg;
  timeunit 1ns;
  timeprecision 1ns;
  // Link timing at the 50 MHz system clock
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned BAUD_HZ    = 115_200;
  // Async bit time rounds down so the bit never stretches past the rate
  localparam logic [15:0] BIT_CYC    = 16'(SYS_CLK_HZ / BAUD_HZ);
  localparam logic [15:0] HALF_CYC   = 16'(SYS_CLK_HZ / BAUD_HZ / 2);
  // Synchronous shift clock dividers
  localparam logic [15:0] SYNC_DIV_SLOW = 16'h000C;
  localparam logic [15:0] SYNC_DIV_FAST = 16'h0004;
  // Frame lengths in bit times, and bits sampled after the start bit
  localparam logic [3:0]  SYNC_BITS  = 4'h8;
  localparam logic [3:0]  A8_BITS    = 4'hA;
  localparam logic [3:0]  A9_BITS    = 4'hB;
  localparam logic [3:0]  A8_SAMPLES = 4'h9;
  localparam logic [3:0]  A9_SAMPLES = 4'hA;

  // Register indices
  localparam logic [2:0] ADDR_CTRL  = 3'h0;
  localparam logic [2:0] ADDR_DATA  = 3'h1;
  localparam logic [2:0] ADDR_SLAVE_ADDRESS_MATCH = 3'h2;
  localparam logic [2:0] ADDR_SLAVE_ADDRESS_MASK = 3'h3;
  localparam logic [2:0] ADDR_VIEW  = 3'h4;
  localparam logic [2:0] ADDR_ISTAT = 3'h5;
  localparam logic [2:0] ADDR_IMASK = 3'h6;

  // Control/status and view register fields
  localparam int unsigned BIT_HI   = 7;
  localparam int unsigned BIT_MID  = 6;
  localparam int unsigned BIT_LO   = 5;
  localparam int unsigned BIT_REN  = 4;
  localparam int unsigned BIT_TB8  = 3;
  localparam int unsigned BIT_RB8  = 2;
  localparam int unsigned BIT_TI   = 1;
  localparam int unsigned BIT_RI   = 0;
  localparam int unsigned BIT_VIEW = 0;

  // Interrupt status bits
  localparam int unsigned IRQ_W   = 5;
  localparam int unsigned IRQ_TX  = 0;
  localparam int unsigned IRQ_RX  = 1;
  localparam int unsigned IRQ_FE  = 2;
  localparam int unsigned IRQ_OV  = 3;
  localparam int unsigned IRQ_COL = 4;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_A8   = 2'h1;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } spsf_req_s;

  typedef enum logic [1:0] {
    SPSF_TX_IDLE  = 2'b01,
    SPSF_TX_SHIFT = 2'b10
  } spsf_tx_e;

  typedef enum logic [3:0] {
    SPSF_RX_IDLE  = 4'b0001,
    SPSF_RX_START = 4'b0010,
    SPSF_RX_DATA  = 4'b0100,
    SPSF_RX_SYNC  = 4'b1000
  } spsf_rx_e;
endpackage : spsf_pkg
`default_nettype wire

/* File: bench/spsf_serial_port_asserts.sv */
`default_nettype none
module spsf_serial_port_asserts
  import spsf_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire spsf_req_s  req_i,
  input wire logic [7:0] rdata_o,
  input wire logic       irq_o,
  input wire logic       rxd_i,
  input wire logic       rxd_o,
  input wire logic       rxd_oe_o,
  input wire logic       txd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned low_q;
  int unsigned low_d;
  logic        clr_req;

  // Length of the current low run on the serial output
  assign low_d   = txd_o ? 0 : low_q + 1;
  assign clr_req = req_i.rd && req_i.addr == ADDR_ISTAT
                || req_i.wr && req_i.addr == ADDR_IMASK;
  always_ff @(posedge ref_clk_i) low_q <= low_d;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_reset_idle: assert property (!$past(rst_n_i) |->
    txd_o && !irq_o && !rxd_oe_o && rdata_o == 8'h00)
    else $error("outputs not idle after reset");
  a_rdata_quiet: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00)
    else $error("read data without a read");
  a_unmapped_read: assert property
    ($past(req_i.rd && req_i.addr == 3'h7) |-> rdata_o == 8'h00)
    else $error("unmapped index read not zero");
  a_sync_low_half: assert property (rxd_oe_o && $fell(txd_o) |->
    (!txd_o[*6] ##1 txd_o) or (!txd_o[*2] ##1 txd_o))
    else $error("shift clock low half wrong");
  a_sync_clk_start: assert property ($rose(rxd_oe_o) |->
    ##[0:12] !txd_o)
    else $error("shift clock did not start");
  a_sync_data_hold: assert property (rxd_oe_o && $past(rxd_oe_o)
    && txd_o && $past(txd_o) |-> $stable(rxd_o))
    else $error("shift data moved while clock high");
  // Sync receive clock runs have oe low, so short runs are left out
  a_async_bit_len: assert property ($rose(txd_o) && !rxd_oe_o
    && low_q > 8 |-> low_q % BIT_CYC == 0)
    else $error("async low run not whole bits");
  a_irq_fall_cause: assert property ($fell(irq_o) |->
    $past(clr_req) || $past(clr_req, 2))
    else $error("interrupt dropped without a clear");

  c_sync_frame: cover property ($rose(rxd_oe_o));
  c_irq_raise: cover property ($rose(irq_o));
  c_async_byte: cover property ($rose(txd_o) && low_q > 400);
endmodule : spsf_serial_port_asserts

bind spsf_serial_port spsf_serial_port_asserts u_chk (.ref_clk_i,
  .rst_n_i, .req_i, .rdata_o, .irq_o, .rxd_i, .rxd_o, .rxd_oe_o, .txd_o);
`default_nettype wire

/* File: bench/spsf_remote_station.sv */
`default_nettype none
module spsf_remote_station
  import spsf_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic txd_i,
  input  wire logic  sync_i,
  input  wire logic  dat_i,
  output logic       line_o,
  output logic [7:0] got_o,
  output logic [7:0] sgot_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Line rests at the pull-up level between frames
  initial line_o = 1'b1;

  // Eight-bit frames get a trailing idle bit, which the line shows anyway
  task automatic send(input logic [7:0] b, input logic n9, nv, stp);
    logic [10:0] f;
    f = n9 ? {stp, nv, b, 1'b0} : {1'b1, stp, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask : send

  always @(negedge txd_i) if (!sync_i) begin
    repeat (HALF_CYC) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      got_o[i] = txd_i;
    end
  end

  // Sync frames: data is steady at each rising shift clock, LSB first
  always @(posedge txd_i) if (sync_i) sgot_o <= {dat_i, sgot_o[7:1]};
endmodule : spsf_remote_station
`default_nettype wire

/* File: bench/spsf_serial_port_tb.sv */
`default_nettype none
module spsf_serial_port_tb
  import spsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk_i, rst_n_i, rxd_o, rxd_oe_o, txd_o, irq_o, line;
  spsf_req_s  req_i;
  logic [7:0] rdata_o, got, sgot;
  int         mismatches, comparisons, cyc;
  wire logic  pin_w = rxd_oe_o ? rxd_o : line;

  spsf_serial_port dut (.ref_clk_i, .rst_n_i, .req_i, .rdata_o, .irq_o,
    .rxd_i(pin_w), .rxd_o, .rxd_oe_o, .txd_o);
  spsf_remote_station rem (.clk_i(ref_clk_i), .txd_i(txd_o),
    .sync_i(rxd_oe_o), .dat_i(pin_w), .line_o(line), .got_o(got),
    .sgot_o(sgot));

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // Budget covers about fifteen frames plus register traffic
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      mismatches = mismatches + 1;
      stop_test();
    end
  end

  task automatic cmp(input string n, input logic [7:0] e, s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : cmp

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    req_i <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk_i);
    req_i <= '0;
    @(posedge ref_clk_i);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] m, e);
    req_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk_i);
    req_i <= '0;
    #1 cmp("read data", e, rdata_o & m);
    @(posedge ref_clk_i);
  endtask : rd

  task automatic rx(input logic [7:0] b, input logic n9, nv, stp,
                    input logic [7:0] e, c);
    rem.send(b, n9, nv, stp);
    rd(ADDR_CTRL, 8'h01, e);
    wr(ADDR_CTRL, c);
  endtask : rx

  // Counts edges from the write until the unmasked tx event shows
  task automatic tx_time(input logic [7:0] d, input int lo, hi);
    int n;
    wr(ADDR_DATA, d);
    n = 1;
    while (irq_o !== 1'b1 && n < 5000) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    cmp("tx done time", 8'h01, {7'h00, n >= lo && n <= hi});
    rd(ADDR_ISTAT, 8'h01, 8'h01);
  endtask : tx_time

  initial begin
    rst_n_i = 1'b0;
    req_i = '0;
    mismatches = 0;
    comparisons = 0;
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    rd(ADDR_CTRL, 8'hFF, 8'h00);
    rd(3'h7, 8'hFF, 8'h00);
    wr(ADDR_IMASK, 8'h01);
    wr(ADDR_CTRL, 8'h40);
    tx_time(8'hA5, 3906, 3914);
    cmp("sent byte", 8'hA5, got);
    rd(ADDR_CTRL, 8'h02, 8'h02);
    rd(ADDR_CTRL, 8'h02, 8'h02);
    #1 cmp("irq", 8'h00, {7'h00, irq_o});
    rx(8'h3C, 1'b0, 1'b0, 1'b1, 8'h00, 8'h50);
    rx(8'h3C, 1'b0, 1'b0, 1'b0, 8'h01, 8'h70);
    #1 cmp("irq", 8'h00, {7'h00, irq_o});
    wr(ADDR_IMASK, 8'h02);
    #1 cmp("irq", 8'h01, {7'h00, irq_o});
    rd(ADDR_ISTAT, 8'h02, 8'h02);
    #1 cmp("irq", 8'h00, {7'h00, irq_o});
    rx(8'h3C, 1'b0, 1'b0, 1'b0, 8'h00, 8'h70);
    rx(8'h3C, 1'b0, 1'b0, 1'b1, 8'h01, 8'h50);
    rem.send(8'h11, 1'b0, 1'b0, 1'b1);
    rem.send(8'h22, 1'b0, 1'b0, 1'b1);
    rd(ADDR_CTRL, 8'hE0, 8'h40);
    wr(ADDR_VIEW, 8'h01);
    rd(ADDR_CTRL, 8'h40, 8'h40);
    rd(ADDR_DATA, 8'hFF, 8'h11);
    rd(ADDR_CTRL, 8'h40, 8'h40);
    wr(ADDR_CTRL, 8'hB0);
    rd(ADDR_CTRL, 8'h40, 8'h00);
    wr(ADDR_VIEW, 8'h00);
    wr(ADDR_SLAVE_ADDRESS_MATCH, 8'h35);
    wr(ADDR_SLAVE_ADDRESS_MASK, 8'hF0);
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_CTRL, 8'hB0 | 8'(m << 6));
      rx(8'h3A, 1'b1, 1'b0, 1'b1, 8'h00, 8'hB0 | 8'(m << 6));
      rx(8'h3A, 1'b1, 1'b1, 1'b1, 8'h01, 8'hB0 | 8'(m << 6));
      rx(8'h4A, 1'b1, 1'b1, 1'b1, 8'h00, 8'h90 | 8'(m << 6));
      rx(8'h4A, 1'b1, 1'b0, 1'b1, 8'h01, 8'h90);
    end
    wr(ADDR_IMASK, 8'h01);
    wr(ADDR_CTRL, 8'h00);
    tx_time(8'h5A, 96, 106);
    cmp("sync byte", 8'h5A, sgot);
    wr(ADDR_CTRL, 8'h20);
    tx_time(8'hC3, 32, 42);
    cmp("sync byte", 8'hC3, sgot);
    stop_test();
  end
endmodule : spsf_serial_port_tb
`default_nettype wire
